// ==== rtl/dphy_pkg.sv ====
// constants, register map and types of the ddr2 phy command and io path
package dphy_pkg;
    // ==========================================================
    // timing
    localparam int unsigned MEM_CYC   = 4;  // sys_clk cycles per memory clock
    localparam int unsigned AC_HOLD   = 2;  // memory cycles an address stands
    localparam int unsigned CS_PULSE  = 1;  // memory cycles a cs/cke/odt pulse stands
    localparam int unsigned DRV_LEN   = AC_HOLD * MEM_CYC;
    localparam int unsigned PULSE_LEN = CS_PULSE * MEM_CYC;
    localparam logic [1:0]  CK_RISE_PH = 2'h2; // phase at which mem_ck has just risen

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0]  REG_CTRL  = 8'h00;
    localparam logic [7:0]  REG_PHASE = 8'h04;
    localparam logic [7:0]  REG_STAT  = 8'h08;

    // ctrl fields
    localparam int unsigned CTRL_OBYP = 0;  // skip output alignment stage
    localparam int unsigned CTRL_IBYP = 1;  // skip input resync stage
    localparam int unsigned CTRL_CAPS = 2;  // capture source, 2 bits
    localparam int unsigned CTRL_DIFF = 4;  // differential strobe
    localparam int unsigned CTRL_WSRC = 5;  // write clock from leveling chain
    localparam int unsigned CTRL_RSRC = 6;  // resync clock from leveling chain
    localparam logic [6:0]  CTRL_RST  = 7'h00;

    // phase fields
    localparam int unsigned PH_ACD  = 0;    // address/command phase step, 2 bits
    localparam int unsigned PH_EDGE = 2;    // launch on falling edge
    localparam int unsigned PH_LVL  = 3;    // leveling delay, 2 bits
    localparam logic [4:0]  PHASE_RST = 5'h00;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        CAP_STROBE = 2'h0,
        CAP_GATED  = 2'h1,
        CAP_GLOBAL = 2'h2
    } dphy_cap_t;

    typedef enum logic [2:0] {
        CS_IDLE = 3'b001,
        CS_WAIT = 3'b010,
        CS_DRV  = 3'b100
    } dphy_cst_t;
endpackage : dphy_pkg

// ==== rtl/dphy_top.sv ====
// ddr2 phy: address/command launch, write serializer and read capture chain
module dphy_top
    import dphy_pkg::*;
#(
    parameter int unsigned DQ_W = 16,
    parameter int unsigned AW   = 14,
    parameter int unsigned BW   = 3
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // core command port
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire logic              cmd_cs_n,
    input  wire logic              cmd_cke,
    input  wire logic              cmd_odt,
    input  wire logic              cmd_ras_n,
    input  wire logic              cmd_cas_n,
    input  wire logic              cmd_we_n,
    input  wire logic [AW-1:0]     cmd_addr,
    input  wire logic [BW-1:0]     cmd_ba,
    // core write port, two words per core cycle
    input  wire logic              wr_valid,
    output logic                   wr_ready,
    input  wire logic [2*DQ_W-1:0] wr_data,
    input  wire logic [2*DQ_W/8-1:0] wr_mask,
    // core read port
    input  wire logic              rd_gate,
    output logic                   rd_valid,
    output logic [2*DQ_W-1:0]      rd_data,
    output logic                   rd_half_clk,
    // memory clock and command pins
    output logic                   mem_ck,
    output logic                   mem_ck_n,
    output logic                   addr_cmd_half_clock,
    output logic                   mem_cs_n,
    output logic                   mem_cke,
    output logic                   mem_odt,
    output logic                   mem_ras_n,
    output logic                   mem_cas_n,
    output logic                   mem_we_n,
    output logic [AW-1:0]          mem_addr,
    output logic [BW-1:0]          mem_ba,
    // memory data pins
    input  wire logic [DQ_W-1:0]   dq_i,
    output logic [DQ_W-1:0]        dq_o,
    output logic                   dq_oe,
    output logic [DQ_W/8-1:0]      dm_o,
    input  wire logic              dqs_i,
    input  wire logic              dqs_n_i,
    output logic                   dqs_o,
    output logic                   dqs_n_o,
    output logic                   dqs_oe
);
    localparam int unsigned NG = DQ_W / 8;

    if (DQ_W == 0 || DQ_W % 8 != 0) begin : g_chk
        $error("dq width must be a nonzero multiple of 8");
    end

    // ==========================================================
    // registers
    logic [6:0]      ctrl_ff;
    logic [4:0]      phase_ff;
    logic [31:0]     prdata_ff;
    logic [7:0]      rdcnt_ff;
    logic            acc, hit;
    logic            obyp, ibyp, diff, wsrc, rsrc;
    logic [1:0]      capsel, acd, lvl, launch_ph, wl_ph;
    logic            edge_sel;
    logic            cmd_busy, wr_busy;
    logic            hr_sel_ff;

    assign acc      = psel & penable;
    assign hit      = (paddr == REG_CTRL) | (paddr == REG_PHASE) | (paddr == REG_STAT);
    assign pready   = 1'b1;                // zero wait states
    assign pslverr  = acc & ~hit;
    assign prdata   = prdata_ff;
    assign obyp     = ctrl_ff[CTRL_OBYP];
    assign ibyp     = ctrl_ff[CTRL_IBYP];
    assign capsel   = ctrl_ff[CTRL_CAPS +: 2];
    assign diff     = ctrl_ff[CTRL_DIFF];
    assign wsrc     = ctrl_ff[CTRL_WSRC];
    assign rsrc     = ctrl_ff[CTRL_RSRC];
    assign acd      = phase_ff[PH_ACD +: 2];
    assign edge_sel = phase_ff[PH_EDGE];
    assign lvl      = phase_ff[PH_LVL +: 2];

    // writes take effect at the access edge; bypass may change at run time
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_ff  <= CTRL_RST;
            phase_ff <= PHASE_RST;
        end else if (acc && pwrite) begin
            if (paddr == REG_CTRL)  ctrl_ff  <= pwdata[6:0];
            if (paddr == REG_PHASE) phase_ff <= pwdata[4:0];
        end
    end

    // read data is fetched in the setup cycle so it stands in the access cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata_ff <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                REG_CTRL:  prdata_ff <= {25'h0, ctrl_ff};
                REG_PHASE: prdata_ff <= {27'h0, phase_ff};
                REG_STAT:  prdata_ff <= {16'h0, rdcnt_ff, 5'h0, hr_sel_ff, wr_busy, cmd_busy};
                default:   prdata_ff <= 32'h0;
            endcase
        end
    end

    // ==========================================================
    // clocks: one memory cycle is four sys_clk phases
    logic [1:0] ph_ff;
    logic       ck_ff, half_ff;

    // ck rises entering phase 2, so phase 1 is the -90 degree point
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ph_ff   <= 2'h0;
            ck_ff   <= 1'b0;
            half_ff <= 1'b0;
        end else begin
            ph_ff <= ph_ff + 2'h1;
            if (ph_ff[0]) ck_ff <= ~ck_ff;
            if (ph_ff == 2'h1) half_ff <= ~half_ff; // one toggle per ck period
        end
    end

    assign mem_ck              = ck_ff;
    assign mem_ck_n            = ~ck_ff;
    assign addr_cmd_half_clock = half_ff;

    // ==========================================================
    // address and command launch
    dphy_cst_t       cst_ff;
    logic [2:0]      drv_ff;
    logic            c_cs_n_ff, c_cke_ff, c_odt_ff, c_ras_ff, c_cas_ff, c_we_ff;
    logic [AW-1:0]   c_addr_ff;
    logic [BW-1:0]   c_ba_ff;
    logic            cs_n_ff, cke_ff, odt_ff, ras_ff, cas_ff, we_ff;
    logic [AW-1:0]   addr_ff;
    logic [BW-1:0]   ba_ff;

    // phase step plus half a cycle for a falling-edge launch
    assign launch_ph = {edge_sel, 1'b0} + acd;
    assign cmd_ready = (cst_ff == CS_IDLE);
    assign cmd_busy  = (cst_ff != CS_IDLE);

    // command sequencer: idle, wait for launch phase, drive two memory cycles
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cst_ff <= CS_IDLE;
            drv_ff <= 3'h0;
        end else begin
            unique case (cst_ff)
                CS_IDLE: if (cmd_valid) cst_ff <= CS_WAIT;
                CS_WAIT: if (ph_ff == launch_ph) begin
                    cst_ff <= CS_DRV;
                    drv_ff <= 3'h0;
                end
                CS_DRV: begin
                    drv_ff <= drv_ff + 3'h1;
                    if (drv_ff == 3'(DRV_LEN - 1)) cst_ff <= CS_IDLE;
                end
            endcase
        end
    end

    // the request is held here so the core may move on
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            {c_cs_n_ff, c_cke_ff, c_odt_ff} <= 3'b100;
            {c_ras_ff, c_cas_ff, c_we_ff}   <= 3'b111;
            c_addr_ff <= '0;
            c_ba_ff   <= '0;
        end else if (cmd_valid && cmd_ready) begin
            {c_cs_n_ff, c_cke_ff, c_odt_ff} <= {cmd_cs_n, cmd_cke, cmd_odt};
            {c_ras_ff, c_cas_ff, c_we_ff}   <= {cmd_ras_n, cmd_cas_n, cmd_we_n};
            c_addr_ff <= cmd_addr;
            c_ba_ff   <= cmd_ba;
        end
    end

    // pin registers change only at launch and at memory cycle boundaries
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            {cs_n_ff, cke_ff, odt_ff} <= 3'b100;
            {ras_ff, cas_ff, we_ff}   <= 3'b111;
            addr_ff <= '0;
            ba_ff   <= '0;
        end else if (cst_ff == CS_WAIT && ph_ff == launch_ph) begin
            {cs_n_ff, cke_ff, odt_ff} <= {c_cs_n_ff, c_cke_ff, c_odt_ff};
            {ras_ff, cas_ff, we_ff}   <= {c_ras_ff, c_cas_ff, c_we_ff};
            addr_ff <= c_addr_ff;
            ba_ff   <= c_ba_ff;
        end else if (cst_ff == CS_DRV && drv_ff == 3'(PULSE_LEN - 1)) begin
            // enable drops after one cycle even in the half-rate path
            {cs_n_ff, cke_ff, odt_ff} <= 3'b100;
        end else if (cst_ff == CS_DRV && drv_ff == 3'(DRV_LEN - 1)) begin
            {ras_ff, cas_ff, we_ff} <= 3'b111;
        end
    end

    assign mem_cs_n  = cs_n_ff;
    assign mem_cke   = cke_ff;
    assign mem_odt   = odt_ff;
    assign mem_ras_n = ras_ff;
    assign mem_cas_n = cas_ff;
    assign mem_we_n  = we_ff;
    assign mem_addr  = addr_ff;
    assign mem_ba    = ba_ff;

    // ==========================================================
    // write path: two core words leave low then high
    logic              wpend_ff, wbusy_ff, oea_ff, oeb_ff, dqsa_ff, dqsb_ff;
    logic [2:0]        wcnt_ff, nxt_wcnt;
    logic [2*DQ_W-1:0] wdat_ff;
    logic [2*NG-1:0]   wmsk_ff;
    logic [DQ_W-1:0]   dqa_ff, dqb_ff;
    logic [NG-1:0]     dma_ff, dmb_ff;

    // leveling chain moves the write launch later by the leveling delay
    assign wl_ph    = wsrc ? lvl : 2'h0;
    assign wr_ready = ~wpend_ff & ~wbusy_ff;
    assign wr_busy  = wpend_ff | wbusy_ff;
    assign nxt_wcnt = wcnt_ff + 3'h1;

    // dq moves at phase 1, dqs one sys cycle later: 90 degrees apart
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wpend_ff <= 1'b0;
            wbusy_ff <= 1'b0;
            wcnt_ff  <= 3'h0;
            oea_ff   <= 1'b0;
            dqsa_ff  <= 1'b0;
            wdat_ff  <= '0;
            wmsk_ff  <= '0;
            dqa_ff   <= '0;
            dma_ff   <= '0;
        end else if (wr_valid && wr_ready) begin
            wpend_ff <= 1'b1;
            wdat_ff  <= wr_data;
            wmsk_ff  <= wr_mask;
        end else if (wpend_ff && ph_ff == wl_ph) begin
            wpend_ff <= 1'b0;
            wbusy_ff <= 1'b1;
            wcnt_ff  <= 3'h0;
            oea_ff   <= 1'b1;
            dqa_ff   <= wdat_ff[DQ_W-1:0];       // low word first
            dma_ff   <= wmsk_ff[NG-1:0];         // high bit masks its byte
        end else if (wbusy_ff) begin
            wcnt_ff <= nxt_wcnt;
            dqsa_ff <= nxt_wcnt[0] ^ nxt_wcnt[1];
            if (wcnt_ff == 3'(MEM_CYC - 1)) begin
                dqa_ff <= wdat_ff[2*DQ_W-1:DQ_W];
                dma_ff <= wmsk_ff[2*NG-1:NG];
            end
            if (wcnt_ff == 3'(DRV_LEN - 1)) begin
                wbusy_ff <= 1'b0;
                oea_ff   <= 1'b0;
                dqsa_ff  <= 1'b0;
            end
        end
    end

    // alignment stage, used unless bypassed
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dqb_ff  <= '0;
            dmb_ff  <= '0;
            oeb_ff  <= 1'b0;
            dqsb_ff <= 1'b0;
        end else begin
            dqb_ff  <= dqa_ff;
            dmb_ff  <= dma_ff;
            oeb_ff  <= oea_ff;
            dqsb_ff <= dqsa_ff;
        end
    end

    // bypass selects the earlier flop, so no cycle is added
    assign dq_o    = obyp ? dqa_ff  : dqb_ff;
    assign dq_oe   = obyp ? oea_ff  : oeb_ff;
    assign dqs_o   = obyp ? dqsa_ff : dqsb_ff;
    assign dqs_n_o = ~dqs_o;
    assign dqs_oe  = dq_oe;

    // each strobe group owns a contiguous byte lane
    for (genvar g = 0; g < NG; g++) begin : g_dm
        assign dm_o[g] = obyp ? dma_ff[g] : dmb_ff[g];
    end

    // ==========================================================
    // read path: strobe is sampled by sys_clk
    logic            p1_ff, p2_ff, n1_ff, n2_ff, prev_ff, stb;
    logic [DQ_W-1:0] d1_ff, d2_ff, cap_ff, rs_ff, lo_ff, word;
    logic            cap_ev, capv_ff, rsv_ff, ev;
    logic [3:0]      capsh_ff;
    logic [2*DQ_W-1:0] rdd_ff;
    logic            rdv_ff, rhc_ff;

    // two-flop synchronisers for strobe and data pins
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            {p1_ff, p2_ff, n1_ff, n2_ff} <= 4'h0;
            d1_ff <= '0;
            d2_ff <= '0;
        end else begin
            {p1_ff, p2_ff} <= {dqs_i, p1_ff};
            {n1_ff, n2_ff} <= {dqs_n_i, n1_ff};
            d1_ff <= dq_i;
            d2_ff <= d1_ff;
        end
    end

    // differential mode needs both legs to agree
    assign stb = diff ? (p2_ff & ~n2_ff) : p2_ff;

    // capture event source
    always_comb begin
        unique case (dphy_cap_t'(capsel))
            CAP_STROBE: cap_ev = stb ^ prev_ff;
            CAP_GATED:  cap_ev = (stb ^ prev_ff) & rd_gate;
            CAP_GLOBAL: cap_ev = (ph_ff == CK_RISE_PH);
            default:    cap_ev = 1'b0;
        endcase
    end

    // first capture register is never bypassed
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prev_ff  <= 1'b0;
            cap_ff   <= '0;
            capv_ff  <= 1'b0;
            capsh_ff <= 4'h0;
        end else begin
            prev_ff  <= stb;
            capv_ff  <= cap_ev;
            capsh_ff <= {capsh_ff[2:0], cap_ev};
            if (cap_ev) cap_ff <= d2_ff;
        end
    end

    // resync stage on the pll phase or the leveling-delayed one
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rs_ff  <= '0;
            rsv_ff <= 1'b0;
        end else begin
            rsv_ff <= rsrc ? capsh_ff[lvl] : capv_ff;
            if (rsrc ? capsh_ff[lvl] : capv_ff) rs_ff <= cap_ff;
        end
    end

    // a leveling delay longer than the strobe period would overrun cap_ff
    assign word = ibyp ? cap_ff  : rs_ff;
    assign ev   = ibyp ? capv_ff : rsv_ff;

    // pair words into one double-width core word, first one low
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hr_sel_ff <= 1'b0;
            lo_ff     <= '0;
            rdd_ff    <= '0;
            rdv_ff    <= 1'b0;
            rhc_ff    <= 1'b0;
            rdcnt_ff  <= 8'h0;
        end else begin
            rdv_ff <= 1'b0;
            if (ev && !hr_sel_ff) begin
                lo_ff     <= word;
                hr_sel_ff <= 1'b1;
            end else if (ev) begin
                rdd_ff    <= {word, lo_ff};
                rdv_ff    <= 1'b1;
                rhc_ff    <= ~rhc_ff;
                hr_sel_ff <= 1'b0;
                rdcnt_ff  <= rdcnt_ff + 8'h1;
            end
        end
    end

    assign rd_valid    = rdv_ff;
    assign rd_data     = rdd_ff;
    assign rd_half_clk = rhc_ff;

    // ==========================================================
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_pulse;
        !mem_cs_n [*4] ##1 mem_cs_n;
    endsequence
    property p_cs_one;
        $fell(mem_cs_n) |-> s_pulse;
    endproperty
    a_cs_one: assert property (p_cs_one) else $error("cs pulse not one ck");

    property p_ac_hold;
        $rose(cst_ff == CS_DRV) |-> ##1 $stable(mem_addr) [*7];
    endproperty
    a_ac_hold: assert property (p_ac_hold) else $error("address not held");

    property p_half;
        $changed(addr_cmd_half_clock) |=> !$changed(addr_cmd_half_clock) [*3]
            ##1 $changed(addr_cmd_half_clock);
    endproperty
    a_half: assert property (p_half) else $error("half clock rate wrong");

    property p_launch;
        $rose(cst_ff == CS_DRV) |-> $past(ph_ff) == $past(launch_ph);
    endproperty
    a_launch: assert property (p_launch) else $error("launch phase wrong");

    property p_dqs90;
        $rose(wbusy_ff) |-> !dqsa_ff ##1 dqsa_ff ##1 dqsa_ff ##1 !dqsa_ff;
    endproperty
    a_dqs90: assert property (p_dqs90) else $error("dqs not 90 after dq");

    property p_order;
        $rose(wbusy_ff) |-> dqa_ff == wdat_ff[DQ_W-1:0]
            ##4 dqa_ff == wdat_ff[2*DQ_W-1:DQ_W];
    endproperty
    a_order: assert property (p_order) else $error("word order wrong");

    property p_align;
        !obyp && $past(!obyp) |-> dq_o == $past(dqa_ff) && dq_oe == $past(oea_ff);
    endproperty
    a_align: assert property (p_align) else $error("align stage latency");

    property p_cap;
        cap_ev |=> cap_ff == $past(d2_ff) && capv_ff;
    endproperty
    a_cap: assert property (p_cap) else $error("capture missed");
endmodule : dphy_top

// ==== test/dphy_mem_model.sv ====
// behavioural memory side: answers reads with strobe-framed word pairs
module dphy_mem_model #(
    parameter int unsigned DQ_W = 16
) (
    // clock
    input  wire logic       sys_clk,
    // read pins toward the phy
    output logic [DQ_W-1:0] dq_i,
    output logic            dqs_i,
    output logic            dqs_n_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====================================
    // idle: strobe low, data zero
    initial begin
        dq_i = '0;
        dqs_i = '0;
        dqs_n_i = '1;
    end
    // one 160 ns strobe period: word a at the rise, b at the fall;
    // data leads each edge by four sys_clk cycles so the synchroniser sees it settled
    task automatic burst(input logic [DQ_W-1:0] a, input logic [DQ_W-1:0] b);
        @(posedge sys_clk);
        dq_i <= a;
        repeat (4) @(posedge sys_clk);
        dqs_i <= '1;
        dqs_n_i <= '0;
        repeat (4) @(posedge sys_clk);
        dq_i <= b;
        repeat (4) @(posedge sys_clk);
        dqs_i <= '0;
        dqs_n_i <= '1;
        // released bus shows the inverse so a stale word never passes
        fork
            begin
                repeat (4) @(posedge sys_clk);
                dq_i <= ~b;
            end
        join_none
    endtask : burst
endmodule : dphy_mem_model

// ==== test/testbench.sv ====
// self-checking bench for the phy command, write and read paths
module testbench
    import dphy_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // =====================================
    // stimulus and observed signals
    logic        sys_clk = '0, rst_n = '0, psel = '0, penable = '0, pwrite = '0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, q, seed = 32'h415f228a;
    logic        pready, pslverr, e, cmd_ready, wr_ready, rd_valid, rd_half_clk;
    logic        cmd_valid = '0, cmd_cs_n = '0, cmd_cke = '1, cmd_odt = '0, cmd_ras_n = '0;
    logic        cmd_cas_n = '1, cmd_we_n = '1, wr_valid = '0, rd_gate = '0;
    logic [13:0] cmd_addr = '0, mem_addr;
    logic [2:0]  cmd_ba = '0, mem_ba;
    logic [31:0] wr_data = '0, rd_data;
    logic [3:0]  wr_mask = '0;
    logic [15:0] dq_i, dq_o;
    logic [1:0]  dm_o;
    logic        mem_ck, mem_ck_n, addr_cmd_half_clock, mem_cs_n, mem_cke, mem_odt;
    logic        mem_ras_n, mem_cas_n, mem_we_n, dq_oe, dqs_i, dqs_n_i, dqs_o, dqs_n_o, dqs_oe;
    logic [7:0]  ra [3] = '{REG_CTRL, REG_PHASE, REG_STAT};
    int          n_fail = 0, checked = 0, npair = 0, l0, l1;
    // =====================================
    // clock, partner and design
    always #5 sys_clk = ~sys_clk;
    dphy_mem_model mem (.sys_clk(sys_clk), .dq_i(dq_i), .dqs_i(dqs_i), .dqs_n_i(dqs_n_i));
    dphy_top uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_cs_n(cmd_cs_n), .cmd_cke(cmd_cke),
        .cmd_odt(cmd_odt), .cmd_ras_n(cmd_ras_n), .cmd_cas_n(cmd_cas_n), .cmd_we_n(cmd_we_n),
        .cmd_addr(cmd_addr), .cmd_ba(cmd_ba), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_data(wr_data), .wr_mask(wr_mask), .rd_gate(rd_gate), .rd_valid(rd_valid),
        .rd_data(rd_data), .rd_half_clk(rd_half_clk), .mem_ck(mem_ck), .mem_ck_n(mem_ck_n),
        .addr_cmd_half_clock(addr_cmd_half_clock), .mem_cs_n(mem_cs_n), .mem_cke(mem_cke),
        .mem_odt(mem_odt), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
        .mem_addr(mem_addr), .mem_ba(mem_ba), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
        .dm_o(dm_o), .dqs_i(dqs_i), .dqs_n_i(dqs_n_i), .dqs_o(dqs_o), .dqs_n_o(dqs_n_o),
        .dqs_oe(dqs_oe)
    );
    // =====================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // low word goes out first, high word in the second memory cycle
    function automatic logic [15:0] slot(input logic [31:0] w, input int s);
        return (s < 4) ? w[15:0] : w[31:16];
    endfunction : slot
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // apb master: setup, then access held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= '1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= '1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= '0;
        penable <= '0;
    endtask : apb
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        apb('1, a, d);
        chk(e, '0);
    endtask : wreg
    // one random command; cs, cke and odt stand one memory cycle, the rest two
    task automatic run_cmd();
        logic [31:0] r;
        int          n;
        r = rnd();
        @(posedge sys_clk);
        cmd_valid <= '1;
        {cmd_we_n, cmd_cas_n, cmd_odt, cmd_ba, cmd_addr} <= r[19:0];
        do @(posedge sys_clk); while (cmd_ready !== 1'b1);
        cmd_valid <= '0;
        while (mem_cs_n !== 1'b0) @(posedge sys_clk);
        chk({mem_we_n, mem_cas_n, mem_odt, mem_cke}, {r[19:17], 1'b1});
        for (n = 0; mem_cs_n === 1'b0 && n < 20; n++) @(posedge sys_clk);
        chk(n, PULSE_LEN);
        for (; mem_ras_n === 1'b0 && n < 20; n++) begin
            chk({mem_ba, mem_addr}, r[16:0]);
            @(posedge sys_clk);
        end
        chk(n, DRV_LEN);
    endtask : run_cmd
    // one write burst with a random mask
    task automatic wr_burst();
        logic [31:0] r;
        r = rnd();
        @(posedge sys_clk);
        wr_valid <= '1;
        wr_data <= r;
        wr_mask <= r[3:0] ^ r[31:28];
        do @(posedge sys_clk); while (wr_ready !== 1'b1);
        wr_valid <= '0;
        while (dq_oe !== 1'b1) @(posedge sys_clk);
        for (int s = 0; s < 8; s++) begin
            chk(dq_o, slot(r, s));
            chk(dm_o, s < 4 ? wr_mask[1:0] : wr_mask[3:2]);
            chk(dqs_o, (s % 4) inside {1, 2});
            chk(dqs_n_o, !((s % 4) inside {1, 2}));
            chk({dq_oe, dqs_oe}, 2'b11);
            @(posedge sys_clk);
        end
        chk({dq_oe, dqs_oe}, 2'b00);
    endtask : wr_burst
    // one read pair; latency counted from the last strobe edge
    task automatic rd_pair(input logic want, output int lat);
        logic [31:0] r;
        logic        h;
        r = rnd();
        h = rd_half_clk;
        mem.burst(r[15:0], r[31:16]);
        for (lat = 0; rd_valid !== 1'b1 && lat < 20; lat++) @(posedge sys_clk);
        chk(rd_valid, want);
        if (want) begin
            npair++;
            chk(rd_data, r);
            chk(rd_half_clk, !h);
        end
    endtask : rd_pair
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    // =====================================
    // main sequence
    initial begin
        int n;
        repeat (12) @(posedge sys_clk);
        rst_n <= '1;
        foreach (ra[i]) begin
            apb('0, ra[i], '0);
            chk(q, '0);
        end
        apb('1, 8'h0c, rnd());
        apb('0, 8'h0c, '0);
        chk(e, 1'b1);
        chk(q, '0);
        wreg(REG_PHASE, 32'h1f);
        apb('0, REG_PHASE, '0);
        chk(q, 32'h1f);
        while (addr_cmd_half_clock !== 1'b0) @(posedge sys_clk);
        while (addr_cmd_half_clock !== 1'b1) @(posedge sys_clk);
        for (n = 0; addr_cmd_half_clock === 1'b1 && n < 20; n++) @(posedge sys_clk);
        chk(n, 4);
        // memory clock: high for half of its four-cycle period, legs opposite
        while (mem_ck !== 1'b0) @(posedge sys_clk);
        while (mem_ck !== 1'b1) @(posedge sys_clk);
        for (n = 0; mem_ck === 1'b1 && mem_ck_n === 1'b0 && n < 20; n++) @(posedge sys_clk);
        chk(n, MEM_CYC / 2);
        for (int p = 0; p < 8; p++) begin
            wreg(REG_PHASE, p);
            run_cmd();
        end
        for (int c = 0; c < 4; c++) begin
            wreg(REG_CTRL, {c[1], 4'h0, c[0]});
            wr_burst();
        end
        wreg(REG_CTRL, '0);
        wreg(REG_PHASE, '0);
        rd_pair('1, l0);
        wreg(REG_CTRL, 32'h02);
        rd_pair('1, l1);
        chk(l0 - l1, 1);
        wreg(REG_CTRL, 32'h04);
        rd_pair('0, l1);
        rd_gate <= '1;
        rd_pair('1, l1);
        wreg(REG_CTRL, 32'h50);
        wreg(REG_PHASE, 32'h10);
        rd_pair('1, l1);
        chk(l1, l0 + 2);
        apb('0, REG_STAT, '0);
        chk(q[15:8], npair);
        // global capture: one word per ck rise, so a pair every two memory cycles
        wreg(REG_CTRL, 32'h08);
        while (rd_valid !== 1'b1) @(posedge sys_clk);
        @(posedge sys_clk);
        for (n = 1; rd_valid !== 1'b1 && n < 20; n++) @(posedge sys_clk);
        chk(n, 2 * MEM_CYC);
        report_and_stop();
    end
    // watchdog: the whole run takes a few hundred cycles
    initial begin
        #100us;
        n_fail++;
        report_and_stop();
    end
endmodule : testbench
